// >>> logic/mix_exec.sv
// Executor for nibble exchange, zero skips, table reads and exclusive-OR instructions.
// How it works
// (RQ1) Memory nibble exchange writes back, flags kept.
// (RQ2) Accumulator gets swapped nibbles, memory kept.
// (RQ3) Skip next instruction when byte is zero.
// (RQ4) Taken skip adds one dummy cycle.
// (RQ5) Copy byte to accumulator, skip if zero.
// (RQ6) Skip when selected bit is zero.
// (RQ7) Table read: low to memory, high latched.
// (RQ8) Without high pointer use low pointer only.
// (RQ9) Last-page read uses low pointer only.
// (RQ10) XOR into accumulator, zero flag only.
// (RQ11) XOR written back to memory byte.
// (RQ12) XOR immediate into accumulator.
// (RQ13) Zero flag set when result zero.
`timescale 1ns/1ps
`default_nettype none
module mix_exec
  import mix_pkg::*;
#(
  parameter bit HAS_TABLE_POINTER_HIGH = 1'b1  // Variant has a high table pointer.
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        op_valid,
  input  wire mix_pkg::mix_op_t            op_sel,
  input  wire logic                        op_imm_sel,
  input  wire logic [mix_pkg::ADDR_W-1:0]  op_addr,
  input  wire logic [2:0]                  op_bit,
  input  wire logic [7:0]                  op_imm,
  input  wire logic [7:0]                  dm_rdata,
  input  wire logic [7:0]                  table_pointer_low,
  input  wire logic [7:0]                  table_pointer_high,
  input  wire logic [mix_pkg::PWORD_W-1:0] pm_rdata,
  input  wire logic                        pm_rvalid,
  output var  logic                        busy,
  output var  logic                        skip_dummy,
  output var  logic                        done,
  output var  logic [7:0]                  acc,
  output var  logic                        zero_flag,
  output var  logic [7:0]                  table_high_byte_latch,
  output var  logic                        pm_req,
  output var  logic [mix_pkg::PADDR_W-1:0] pm_addr,
  output var  logic                        dm_we,
  output var  logic [7:0]                  dm_waddr,
  output var  logic [7:0]                  dm_wdata
);
  import mix_pkg::*;

  // ****************************************
  // State
  // ****************************************
  // Executor phases, one-hot.
  typedef enum logic [2:0] {
    MIX_ST_IDLE  = 3'b001,
    MIX_ST_TBL   = 3'b010,
    MIX_ST_DUMMY = 3'b100
  } mix_st_t;

  // All registered state of the executor.
  typedef struct packed {
    mix_st_t              st;
    logic [7:0]           acc;
    logic                 zf;
    logic [7:0]           tbh;
    logic [ADDR_W-1:0]    dst;
    logic                 pm_req;
    logic [PADDR_W-1:0]   pm_addr;
    logic                 done;
    logic                 dummy;
    logic                 busy;
  } mix_st_all_t;
  mix_st_all_t s_q;  // Registered state.
  mix_st_all_t s_d;  // Next state.

  mix_mem_if wr_if ();  // Write request toward the output stage.

  // Last program page starts where all upper address bits are one.
  localparam logic [PADDR_W-1:0] LAST_PAGE = {{(PADDR_W-8){1'b1}}, 8'h00};

  // Swaps the two nibbles of a byte.
  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  // Decodes the instruction and forms next state and write request.
  always_comb
  begin
    logic [7:0] xr;
    logic       skip;
    xr              = s_q.acc ^ (op_imm_sel ? op_imm : dm_rdata);
    skip            = 1'b0;
    s_d             = s_q;
    s_d.done        = 1'b0;
    s_d.dummy       = 1'b0;
    wr_if.wr_en     = 1'b0;
    wr_if.wr_addr   = op_addr;
    wr_if.wr_data   = 8'h00;
    case (s_q.st)
      MIX_ST_IDLE:
      begin
        if (op_valid)
        begin
          case (op_sel)
            MIX_OP_SWAPM:
            begin
              wr_if.wr_en   = 1'b1;               // [RQ1]
              wr_if.wr_data = nib_swap(dm_rdata); // [RQ1]
              s_d.done      = 1'b1;
            end
            MIX_OP_SWAPACC:
            begin
              s_d.acc  = nib_swap(dm_rdata); // [RQ2]
              s_d.done = 1'b1;
            end
            MIX_OP_SKZ:
            begin
              skip = (dm_rdata == 8'h00); // [RQ3]
            end
            MIX_OP_SKZCPY:
            begin
              s_d.acc = dm_rdata;           // [RQ5]
              skip    = (dm_rdata == 8'h00); // [RQ5]
            end
            MIX_OP_SKBIT:
            begin
              skip = ~dm_rdata[op_bit]; // [RQ6]
            end
            MIX_OP_TBRCUR:
            begin
              s_d.st      = MIX_ST_TBL;
              s_d.dst     = op_addr;
              s_d.pm_req  = 1'b1;
              // Without a high pointer the upper bits stay zero. [RQ8]
              s_d.pm_addr = HAS_TABLE_POINTER_HIGH ?
                PADDR_W'({table_pointer_high, table_pointer_low}) :
                PADDR_W'(table_pointer_low); // [RQ7]
            end
            MIX_OP_TBRLAST:
            begin
              s_d.st      = MIX_ST_TBL;
              s_d.dst     = op_addr;
              s_d.pm_req  = 1'b1;
              s_d.pm_addr = LAST_PAGE | PADDR_W'(table_pointer_low); // [RQ9]
            end
            MIX_OP_XORACC:
            begin
              s_d.acc  = xr;             // [RQ10] [RQ12]
              s_d.zf   = (xr == 8'h00);  // [RQ13]
              s_d.done = 1'b1;
            end
            MIX_OP_XORMEM:
            begin
              wr_if.wr_en   = 1'b1;          // [RQ11]
              wr_if.wr_data = xr;            // [RQ11]
              s_d.zf        = (xr == 8'h00); // [RQ13]
              s_d.done      = 1'b1;
            end
            default:
            begin
              s_d.done = 1'b1;
            end
          endcase
          // A taken skip inserts one dummy cycle before completion.
          if (skip)
          begin
            s_d.st    = MIX_ST_DUMMY; // [RQ4]
            s_d.dummy = 1'b1;         // [RQ4]
          end
          else if (op_sel == MIX_OP_SKZ || op_sel == MIX_OP_SKZCPY || op_sel == MIX_OP_SKBIT)
          begin
            s_d.done = 1'b1;
          end
        end
      end
      MIX_ST_TBL:
      begin
        // Waits for the program word, then stores both halves.
        if (pm_rvalid)
        begin
          s_d.pm_req    = 1'b0;
          wr_if.wr_en   = 1'b1;               // [RQ7] [RQ9]
          wr_if.wr_addr = s_q.dst;
          wr_if.wr_data = pm_rdata[7:0];
          s_d.tbh       = pm_rdata[15:8];     // [RQ7] [RQ9]
          s_d.st        = MIX_ST_IDLE;
          s_d.done      = 1'b1;
        end
      end
      MIX_ST_DUMMY:
      begin
        // Second cycle of a taken skip.
        s_d.st   = MIX_ST_IDLE;
        s_d.done = 1'b1;
      end
      default:
      begin
        s_d.st = MIX_ST_IDLE;
      end
    endcase
    // Busy is kept as a register so that the output comes from a flip-flop.
    s_d.busy = (s_d.st != MIX_ST_IDLE);
  end

  // Registers the whole state with a synchronous reset.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_q         <= '0;
      s_q.st      <= MIX_ST_IDLE;
      s_q.acc     <= ACC_RST;
      s_q.tbh     <= TBH_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Write stage keeps memory outputs registered.
  mix_wr_stage u_wr (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .wr       (wr_if.dst),
    .dm_we    (dm_we),
    .dm_waddr (dm_waddr),
    .dm_wdata (dm_wdata)
  );

  assign busy                  = s_q.busy;
  assign skip_dummy            = s_q.dummy;
  assign done                  = s_q.done;
  assign acc                   = s_q.acc;
  assign zero_flag             = s_q.zf;
  assign table_high_byte_latch = s_q.tbh;
  assign pm_req                = s_q.pm_req;
  assign pm_addr               = s_q.pm_addr;

  // ****************************************
  // Checks
  // ****************************************
  a_skip_dummy: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ4]
    skip_dummy |=> done && !busy) else $error("Skip did not end after dummy.");
  a_zero_skip: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ3]
    (!busy && op_valid && op_sel == MIX_OP_SKZ && dm_rdata == 8'h00) |=> skip_dummy)
    else $error("Zero byte did not skip.");
  a_bit_skip: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ6]
    (!busy && op_valid && op_sel == MIX_OP_SKBIT && dm_rdata[op_bit]) |=> !skip_dummy && done)
    else $error("Set bit skipped.");
  a_swap_acc: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ2]
    (!busy && op_valid && op_sel == MIX_OP_SWAPACC) |=> acc == {$past(dm_rdata[3:0]),
    $past(dm_rdata[7:4])}) else $error("Accumulator swap wrong.");
  a_swap_mem: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ1]
    (!busy && op_valid && op_sel == MIX_OP_SWAPM) |=> dm_we &&
    dm_wdata == {$past(dm_rdata[3:0]), $past(dm_rdata[7:4])}) else $error("Memory swap.");
  a_xor_zero: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ13]
    (!busy && op_valid && op_sel == MIX_OP_XORACC) |=> zero_flag == (acc == 8'h00))
    else $error("Zero flag wrong.");
  a_copy_acc: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ5]
    (!busy && op_valid && op_sel == MIX_OP_SKZCPY) |=> acc == $past(dm_rdata))
    else $error("Copy to accumulator wrong.");
  a_flag_keep: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ1]
    (!busy && op_valid && op_sel != MIX_OP_XORACC && op_sel != MIX_OP_XORMEM)
    |=> $stable(zero_flag)) else $error("Flag changed.");
  a_last_page: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RQ9]
    (!busy && op_valid && op_sel == MIX_OP_TBRLAST) |=> pm_req &&
    pm_addr == (LAST_PAGE | PADDR_W'($past(table_pointer_low)))) else $error("Last page.");
  c_skip: cover property (@(posedge ref_clk) skip_dummy);
  c_table: cover property (@(posedge ref_clk) pm_req && pm_rvalid);
  c_xor_zero: cover property (@(posedge ref_clk) zero_flag);
endmodule
`default_nettype wire

// >>> logic/mix_mem_if.sv
// Interface that carries the memory access group between the executor and its port stage.
`timescale 1ns/1ps
`default_nettype none
interface mix_mem_if;
  logic       wr_en;    // Data memory write strobe.
  logic [7:0] wr_addr;  // Data memory write address.
  logic [7:0] wr_data;  // Data memory write data.
  modport src (output wr_en, output wr_addr, output wr_data);
  modport dst (input wr_en, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// >>> logic/mix_pkg.sv
// Package of opcodes, widths and reset values for the instruction tail executor.
package mix_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 8;    // Data byte width.
  localparam int ADDR_W = 8;    // Data memory address width.
  localparam int PADDR_W = 12;  // Program memory address width.
  localparam int PWORD_W = 16;  // Program word width.
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACC_RST = 8'h00;  // Accumulator after reset.
  localparam logic [7:0] TBH_RST = 8'h00;  // Table high latch after reset.

  // Operation selector, one-hot.
  typedef enum logic [9:0] {
    MIX_OP_NONE    = 10'h001,
    MIX_OP_SWAPM   = 10'h002,
    MIX_OP_SWAPACC = 10'h004,
    MIX_OP_SKZ     = 10'h008,
    MIX_OP_SKZCPY  = 10'h010,
    MIX_OP_SKBIT   = 10'h020,
    MIX_OP_TBRCUR  = 10'h040,
    MIX_OP_TBRLAST = 10'h080,
    MIX_OP_XORACC  = 10'h100,
    MIX_OP_XORMEM  = 10'h200
  } mix_op_t;
endpackage

// >>> logic/mix_wr_stage.sv
// Output register stage for data memory writes.
`timescale 1ns/1ps
`default_nettype none
module mix_wr_stage
  import mix_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  mix_mem_if.dst          wr,
  output var  logic       dm_we,
  output var  logic [7:0] dm_waddr,
  output var  logic [7:0] dm_wdata
);
  // State of this stage.
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } mix_wst_t;
  mix_wst_t s_q;  // Registered state.
  mix_wst_t s_d;  // Next state.

  // Captures the write request every cycle.
  always_comb
  begin
    s_d.we   = wr.wr_en;
    s_d.addr = wr.wr_addr;
    s_d.data = wr.wr_data;
  end

  // Registers the stage with a synchronous reset.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dm_we    = s_q.we;
  assign dm_waddr = s_q.addr;
  assign dm_wdata = s_q.data;
endmodule
`default_nettype wire

// >>> test/mcu_instr_subset_exec_bench.sv
// Self-checking bench that runs random and corner operations through the executor.
`timescale 1ns/1ps
`default_nettype none
module mcu_instr_subset_exec_bench;
  import mix_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_imm_sel = 1'b0, slow = 1'b0;
  mix_op_t op_sel = MIX_OP_NONE;
  logic [7:0] op_addr = 8'h00, op_imm = 8'h00, tpl = 8'h00, tph = 8'h00, dm_rdata;
  logic [2:0] op_bit = 3'h0;
  logic [15:0] pm_rdata;
  logic [11:0] pm_addr;
  logic [7:0] acc, latch, dm_waddr, dm_wdata;
  logic busy, skip_dummy, done, zero_flag, pm_req, pm_rvalid, dm_we, sk, pz, bz;
  logic [11:0] pa_nh;  // Program address formed by the variant without a high pointer.
  int bad_count = 0, compares = 0, cyc = 0, n;
  mix_op_t ops [10] = '{MIX_OP_SWAPM, MIX_OP_SWAPACC, MIX_OP_SKZ, MIX_OP_SKZCPY, MIX_OP_SKBIT,
    MIX_OP_TBRCUR, MIX_OP_TBRLAST, MIX_OP_XORACC, MIX_OP_XORACC, MIX_OP_XORMEM};
  logic [31:0] r = 32'h68A5D01F;
  logic [7:0] a, d, pa;
  logic [15:0] w;
  always #20 ref_clk = ~ref_clk;
  mix_exec uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_sel(op_sel),
    .op_imm_sel(op_imm_sel), .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm),
    .dm_rdata(dm_rdata), .table_pointer_low(tpl), .table_pointer_high(tph),
    .pm_rdata(pm_rdata), .pm_rvalid(pm_rvalid), .busy(busy), .skip_dummy(skip_dummy),
    .done(done), .acc(acc), .zero_flag(zero_flag), .table_high_byte_latch(latch),
    .pm_req(pm_req), .pm_addr(pm_addr), .dm_we(dm_we), .dm_waddr(dm_waddr),
    .dm_wdata(dm_wdata));
  mix_mem_model mem (.ref_clk(ref_clk), .slow(slow), .dm_addr(op_addr), .dm_rdata(dm_rdata),
    .dm_we(dm_we), .dm_waddr(dm_waddr), .dm_wdata(dm_wdata), .pm_req(pm_req),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pm_rvalid(pm_rvalid));
  // Variant without a high table pointer runs in lock step; only its fetch address is watched.
  mix_exec #(.HAS_TABLE_POINTER_HIGH(1'b0)) uut_nohigh (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_sel(op_sel), .op_imm_sel(op_imm_sel), .op_addr(op_addr),
    .op_bit(op_bit), .op_imm(op_imm), .dm_rdata(dm_rdata), .table_pointer_low(tpl),
    .table_pointer_high(tph), .pm_rdata(pm_rdata), .pm_rvalid(pm_rvalid), .busy(),
    .skip_dummy(), .done(), .acc(), .zero_flag(), .table_high_byte_latch(), .pm_req(),
    .pm_addr(pa_nh), .dm_we(), .dm_waddr(), .dm_wdata());
  // Next value of the shared pseudo-random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // Program word the memory should hold at a given address.
  function automatic logic [15:0] pword(input logic [11:0] ad);
    return {ad[7:0] ^ 8'h3C, ad[11:4]};
  endfunction
  // Byte with its two nibbles exchanged.
  function automatic logic [7:0] nswap(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction
  // Compares one observed value with its expectation and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Issues one operation, counts cycles to completion and lets any write land.
  task automatic run_op(input mix_op_t o, input logic s);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_sel = o;
    op_imm_sel = s;
    @(negedge ref_clk);
    op_valid = 1'b0;
    bz = busy;
    n = 1;
    sk = 1'b0;
    while (done !== 1'b1 && n < 40)
    begin
      sk = sk | (skip_dummy === 1'b1);
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
  endtask
  // Cuts a hung run short.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("acc_rst", acc, ACC_RST);
    chk("latch_rst", latch, TBH_RST);
    for (int i = 0; i < 24; i++)
    begin
      for (int k = 0; k < 10; k++)
      begin
        r = lfsr(r);
        a = r[7:0];
        d = (i % 5 == 0) ? 8'h00 : ((i % 5 == 1) ? acc : r[15:8]);
        mem.ram[a] = d;
        op_addr = a;
        op_imm = (i % 5 == 2) ? acc : r[23:16];
        op_bit = r[26:24];
        tpl = r[31:24];
        tph = r[15:8];
        slow = r[27];
        pa = acc;
        pz = zero_flag;
        run_op(ops[k], k == 8);
        if (k < 7) chk("zflag_kept", zero_flag, pz);
        if (k > 0 && k < 5) chk("mem_kept", mem.ram[a], d);
        if (k < 2 || k > 6) chk("busy_single", bz, 1'b0);
        case (k)
          0: chk("swap_mem", mem.ram[a], nswap(d));
          1: chk("swap_acc", acc, nswap(d));
          2: chk("skz_cyc", {bz, sk, 8'(n)}, (d == 8'h00) ? 10'h302 : 10'h001);
          3: chk("skzcpy", {bz, sk, 8'(n), acc}, {(d == 8'h00) ? 10'h302 : 10'h001, d});
          4: chk("skbit_cyc", {bz, sk, 8'(n)}, d[op_bit] ? 10'h001 : 10'h302);
          5, 6:
          begin
            w = pword({(k == 5) ? tph[3:0] : 4'hF, tpl});
            chk("tbl_addr", mem.last_pa, {(k == 5) ? tph[3:0] : 4'hF, tpl});
            chk("tbl_low", mem.ram[a], w[7:0]);
            chk("tbl_high", latch, w[15:8]);
            chk("tbl_busy", bz, 1'b1);
            chk("tbl_nohigh", pa_nh, {(k == 5) ? 4'h0 : 4'hF, tpl});
          end
          7: chk("xor_mem_acc", {zero_flag, acc}, {(pa ^ d) == 8'h00, pa ^ d});
          8: chk("xor_imm", {zero_flag, acc}, {(pa ^ op_imm) == 8'h00, pa ^ op_imm});
          default: chk("xor_to_mem", {zero_flag, mem.ram[a]}, {(pa ^ d) == 8'h00, pa ^ d});
        endcase
      end
      $display("test %0d ended", i);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> test/mix_mem_model.sv
// Behavioural data and program memory that serve the instruction tail executor.
`timescale 1ns/1ps
`default_nettype none
module mix_mem_model
(
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic [7:0]  dm_addr,
  output var  logic [7:0]  dm_rdata,
  input  wire logic        dm_we,
  input  wire logic [7:0]  dm_waddr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        pm_req,
  input  wire logic [11:0] pm_addr,
  output var  logic [15:0] pm_rdata,
  output var  logic        pm_rvalid
);
  logic [7:0]  ram [256];  // Data memory bytes, preloaded by the bench.
  logic [11:0] last_pa;    // Program address of the last answered fetch.
  logic [2:0]  wait_q;     // Cycles spent holding off a fetch.
  initial
  begin
    pm_rvalid = 1'b0;
    pm_rdata = 16'h0000;
    wait_q = 3'h0;
  end
  // The addressed byte is offered in the same cycle.
  assign dm_rdata = ram[dm_addr];
  // A write strobe stores one byte at the next edge.
  always @(posedge ref_clk)
    if (dm_we === 1'b1)
      ram[dm_waddr] <= dm_wdata;
  // Fetches answer at once or after four waits; the word toggles outside its valid cycle.
  always @(posedge ref_clk)
  begin
    if (pm_rvalid)
    begin
      pm_rvalid <= 1'b0;
      pm_rdata <= ~pm_rdata;
      wait_q <= 3'h0;
    end
    else if (pm_req === 1'b1 && wait_q >= (slow ? 3'h4 : 3'h0))
    begin
      pm_rvalid <= 1'b1;
      pm_rdata <= {pm_addr[7:0] ^ 8'h3C, pm_addr[11:4]};
      last_pa <= pm_addr;
    end
    else
    begin
      pm_rdata <= ~pm_rdata;
      wait_q <= (pm_req === 1'b1) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule
`default_nettype wire
